// ==== logic/rps_map.svh ====
// Register offsets, field positions, reset values and command codes of
// the RAM pointer and indirect select register bank.
// Assumes inclusion by bare name from each design module.
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH

// ****************************************************************
// Register offsets on the 4-bit register port
// ****************************************************************
`define RPS_OFS_STATUS 4'h0
`define RPS_OFS_CMD 4'h1
`define RPS_OFS_PTR_HI 4'h2
`define RPS_OFS_PTR_LO 4'h3
`define RPS_OFS_DATA 4'h4
`define RPS_OFS_SUBSEL 4'h5
`define RPS_OFS_CONFIG 4'h6
`define RPS_OFS_INDIRECT 4'h7

// ****************************************************************
// Command codes
// ****************************************************************
`define RPS_CMD_CLR_RX 8'h08
`define RPS_CMD_START 8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define RPS_PH_DIR_BIT 7
`define RPS_PH_STEP_BIT 6
`define RPS_CFG_CCHEN_BIT 6
`define RPS_SUB_TOP_BIT 2
`define RPS_S2_MULT_HI_BIT 7
`define RPS_S2_MULT_LO_BIT 6
`define RPS_ST_HALT_BIT 0

// ****************************************************************
// Indirect selector codes and reset values
// ****************************************************************
`define RPS_SEL_TENT_ID 3'h0
`define RPS_SEL_NODE_ID 3'h1
`define RPS_SEL_SETUP1 3'h2
`define RPS_SEL_NEXT_ID 3'h3
`define RPS_SEL_SETUP2 3'h4
`define RPS_RST_BYTE 8'h00
`define RPS_RST_PTR 11'h000

`endif

// ==== logic/rps_pkg.sv ====
// Types shared by the RAM pointer and indirect select register bank.
// Assumes the map header is on the include path.
package rps_pkg;
  // Register port request as one bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rps_bus_s;

  // Pointer state: direction, step enable and the 11-bit address
  typedef struct packed {
    logic read_direction_flag;
    logic pointer_step_enable;
    logic [10:0] addr;
  } rps_ptr_s;

  // Internal operation state, one bit so Gray by construction
  typedef enum logic {
    RPS_RUN = 1'b0,
    RPS_HALT = 1'b1
  } rps_run_e;
endpackage

// ==== logic/rps_ptr.sv ====
// RAM address pointer with direction flag and auto-increment.
// Assumes one clock, synchronous active-low reset, one strobe at a time.
`timescale 1ns/1ps
module rps_ptr
  import rps_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wr_hi,
  input wire logic i_wr_lo,
  input wire logic [7:0] i_wdata,
  input wire logic i_step,
  output rps_ptr_s o_ptr
);
  `include "rps_map.svh"

  // ****************************************************************
  // Pointer register
  // ****************************************************************
  // Loads win over stepping; the port never presents both at once
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_ptr <= '0;
    end
    else if (i_wr_hi)
    begin
      o_ptr.read_direction_flag <= i_wdata[`RPS_PH_DIR_BIT];
      o_ptr.pointer_step_enable <= i_wdata[`RPS_PH_STEP_BIT];
      o_ptr.addr[10:8] <= i_wdata[2:0];
    end
    else if (i_wr_lo)
    begin
      o_ptr.addr[7:0] <= i_wdata;
    end
    else if (i_step && o_ptr.pointer_step_enable)
    begin
      // Carry runs from low into high field, wraps at 2K
      o_ptr.addr <= o_ptr.addr + 11'h001;
    end
  end
endmodule

// ==== logic/rps_cmd.sv ====
// Decoder for the clear-receive-interrupt and start-operation commands.
// Assumes the command strobe lasts one cycle with the code beside it.
`timescale 1ns/1ps
module rps_cmd
  import rps_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_chain_en,
  output logic o_clear_rx,
  output logic o_start
);
  `include "rps_map.svh"

  // ****************************************************************
  // Command pulses
  // ****************************************************************
  // Clear receive interrupt only means something with chaining on
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_clear_rx <= 1'b0;
    end
    else
    begin
      o_clear_rx <= i_cmd_wr && i_chain_en &&
                    (i_wdata == `RPS_CMD_CLR_RX);
    end
  end

  // Start pulse is taken by the halt state machine
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_start <= 1'b0;
    end
    else
    begin
      o_start <= i_cmd_wr && (i_wdata == `RPS_CMD_START);
    end
  end
endmodule

// ==== logic/rps_top.sv ====
// Top of the RAM pointer and indirect select register bank, with the
// 2K buffer RAM, the configuration byte and the indirect registers.
// Assumes a host on the plain register port, one clock, sync reset.
//
// Function
// - Command 08 clears receive interrupt, chaining only
// - Multiplier change halts; command 18 resumes operation
// - Pointer high bit 7 picks access direction
// - Pointer high bit 6 enables step per access
// - Pointer high bits 2..0 give address 10..8
// - Pointer low byte gives address 7..0
// - Three-bit selector routes the indirect window
// - Low selector bits shared with configuration register
// - Configuration write clears top selector bit
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
module rps_top
  import rps_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_next_node_id,
  output logic [7:0] o_rdata,
  output logic o_clear_rx_irq,
  output logic o_internal_halted,
  output logic [7:0] o_config,
  output logic [1:0] o_clock_mult_sel
);
  `include "rps_map.svh"

  // ****************************************************************
  // Request decode
  // ****************************************************************
  rps_bus_s bus;
  rps_ptr_s ptr;
  rps_run_e run_state;
  rps_run_e next_run_state;
  logic wr_cmd;
  logic wr_ptr_hi;
  logic wr_ptr_lo;
  logic wr_data;
  logic rd_data;
  logic wr_sub;
  logic wr_cfg;
  logic wr_ind;
  logic data_access;
  logic start_pulse;
  logic halt_req;
  logic [5:0] cfg_upper;
  logic [1:0] indirect_select_lo;
  logic indirect_select_top_bit;
  logic [2:0] indirect_sel;
  logic [7:0] tent_id;
  logic [7:0] node_id;
  logic [7:0] setup1;
  logic [7:0] setup2;
  logic [7:0] ram_q;
  logic [7:0] next_rdata;
  logic [7:0] ram [0:2047];

  // Bundle the port so the decode reads as one request
  assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  // One write strobe per offset 1 to 7, plus a read strobe for the data offset
  assign wr_cmd = bus.wr && (bus.addr == `RPS_OFS_CMD);
  assign wr_ptr_hi = bus.wr && (bus.addr == `RPS_OFS_PTR_HI);
  assign wr_ptr_lo = bus.wr && (bus.addr == `RPS_OFS_PTR_LO);
  assign wr_data = bus.wr && (bus.addr == `RPS_OFS_DATA);
  assign rd_data = bus.rd && (bus.addr == `RPS_OFS_DATA);
  assign wr_sub = bus.wr && (bus.addr == `RPS_OFS_SUBSEL);
  assign wr_cfg = bus.wr && (bus.addr == `RPS_OFS_CONFIG);
  assign wr_ind = bus.wr && (bus.addr == `RPS_OFS_INDIRECT);

  // Any access to the data window counts as a step, whichever way
  assign data_access = wr_data || rd_data;

  // ****************************************************************
  // Pointer and command sub-blocks
  // ****************************************************************
  rps_ptr u_ptr
  (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_wr_hi(wr_ptr_hi),
    .i_wr_lo(wr_ptr_lo),
    .i_wdata(bus.wdata),
    .i_step(data_access),
    .o_ptr(ptr)
  );

  rps_cmd u_cmd
  (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_cmd_wr(wr_cmd),
    .i_wdata(bus.wdata),
    .i_chain_en(cfg_upper[`RPS_CFG_CCHEN_BIT - 2]),
    .o_clear_rx(o_clear_rx_irq),
    .o_start(start_pulse)
  );

  // ****************************************************************
  // Buffer RAM
  // ****************************************************************
  // Writes only land while the direction flag says write
  always_ff @(posedge i_mclk)
  begin
    if (wr_data && !ptr.read_direction_flag)
    begin
      ram[ptr.addr] <= bus.wdata;
    end
  end

  // Read port is combinational; o_rdata registers it
  assign ram_q = ram[ptr.addr];

  // ****************************************************************
  // Configuration and selector storage
  // ****************************************************************
  // Upper six configuration bits live apart from the shared pair
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      cfg_upper <= 6'h00;
    end
    else if (wr_cfg)
    begin
      cfg_upper <= bus.wdata[7:2];
    end
  end

  // One copy of the low selector pair serves both registers
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      indirect_select_lo <= 2'h0;
    end
    else if (wr_cfg || wr_sub)
    begin
      indirect_select_lo <= bus.wdata[1:0];
    end
  end

  // Top selector bit drops on every configuration write
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      indirect_select_top_bit <= 1'b0;
    end
    else if (wr_cfg)
    begin
      indirect_select_top_bit <= 1'b0;
    end
    else if (wr_sub)
    begin
      indirect_select_top_bit <= bus.wdata[`RPS_SUB_TOP_BIT];
    end
  end

  assign indirect_sel = {indirect_select_top_bit, indirect_select_lo};
  assign o_config = {cfg_upper, indirect_select_lo};

  // ****************************************************************
  // Indirect registers behind the window
  // ****************************************************************
  // Next ID is read-only; reserved codes swallow writes silently
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      tent_id <= `RPS_RST_BYTE;
      node_id <= `RPS_RST_BYTE;
      setup1 <= `RPS_RST_BYTE;
      setup2 <= `RPS_RST_BYTE;
    end
    else if (wr_ind)
    begin
      case (indirect_sel)
        `RPS_SEL_TENT_ID: tent_id <= bus.wdata;
        `RPS_SEL_NODE_ID: node_id <= bus.wdata;
        `RPS_SEL_SETUP1: setup1 <= bus.wdata;
        `RPS_SEL_SETUP2: setup2 <= bus.wdata;
        default: tent_id <= tent_id;
      endcase
    end
  end

  assign o_clock_mult_sel = {setup2[`RPS_S2_MULT_HI_BIT],
                             setup2[`RPS_S2_MULT_LO_BIT]};

  // ****************************************************************
  // Internal operation halt
  // ****************************************************************
  // Halt only when a multiplier bit really changes value
  assign halt_req = wr_ind && (indirect_sel == `RPS_SEL_SETUP2) &&
                    ({bus.wdata[`RPS_S2_MULT_HI_BIT],
                      bus.wdata[`RPS_S2_MULT_LO_BIT]} !=
                     o_clock_mult_sel);

  // Halt wins over a start in the same cycle so no change is missed
  always_comb
  begin
    next_run_state = run_state;
    case (run_state)
      RPS_RUN:
      begin
        if (halt_req)
        begin
          next_run_state = RPS_HALT;
        end
      end
      RPS_HALT:
      begin
        if (start_pulse && !halt_req)
        begin
          next_run_state = RPS_RUN;
        end
      end
      default: next_run_state = RPS_RUN;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      run_state <= RPS_RUN;
    end
    else
    begin
      run_state <= next_run_state;
    end
  end

  assign o_internal_halted = (run_state == RPS_HALT);

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Reserved bits and unmapped offsets read as zero
  always_comb
  begin
    next_rdata = 8'h00;
    case (bus.addr)
      `RPS_OFS_STATUS: next_rdata[`RPS_ST_HALT_BIT] = o_internal_halted;
      `RPS_OFS_PTR_HI: next_rdata = {ptr.read_direction_flag,
                                     ptr.pointer_step_enable,
                                     3'h0, ptr.addr[10:8]};
      `RPS_OFS_PTR_LO: next_rdata = ptr.addr[7:0];
      `RPS_OFS_DATA: next_rdata = ptr.read_direction_flag ?
                                  ram_q : 8'h00;
      `RPS_OFS_SUBSEL: next_rdata = {5'h00, indirect_sel};
      `RPS_OFS_CONFIG: next_rdata = o_config;
      `RPS_OFS_INDIRECT:
      begin
        case (indirect_sel)
          `RPS_SEL_TENT_ID: next_rdata = tent_id;
          `RPS_SEL_NODE_ID: next_rdata = node_id;
          `RPS_SEL_SETUP1: next_rdata = setup1;
          `RPS_SEL_NEXT_ID: next_rdata = i_next_node_id;
          `RPS_SEL_SETUP2: next_rdata = setup2;
          default: next_rdata = 8'h00;
        endcase
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 8'h00;
    end
    else if (bus.rd)
    begin
      o_rdata <= next_rdata;
    end
    else
    begin
      o_rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  a_clear_rx_cmd: assert property (
    wr_cmd && (i_wdata == `RPS_CMD_CLR_RX) |=>
      (o_clear_rx_irq == $past(o_config[`RPS_CFG_CCHEN_BIT])))
    else $error("clear receive pulse wrong for chaining state");

  a_halt_on_mult: assert property (
    halt_req |=> o_internal_halted [*2])
    else $error("multiplier change did not halt operation");

  a_start_resumes: assert property (
    (o_internal_halted && wr_cmd && (i_wdata == `RPS_CMD_START))
      ##1 !halt_req |=> !o_internal_halted)
    else $error("start command did not resume operation");

  a_halt_holds: assert property (
    o_internal_halted && !start_pulse |=> o_internal_halted)
    else $error("halt left without start command");

  a_dir_read_gate: assert property (
    rd_data && !ptr.read_direction_flag |=> (o_rdata == 8'h00))
    else $error("data read returned data in write direction");

  a_step_enabled: assert property (
    data_access && ptr.pointer_step_enable |=>
      (ptr.addr == $past(ptr.addr) + 11'h001))
    else $error("pointer did not step by one");

  a_step_disabled: assert property (
    data_access && !ptr.pointer_step_enable |=> $stable(ptr.addr))
    else $error("pointer moved with stepping off");

  a_upper_load: assert property (
    wr_ptr_hi |=> (ptr.addr[10:8] == $past(i_wdata[2:0])) &&
                  (ptr.addr[7:0] == $past(ptr.addr[7:0])))
    else $error("upper pointer bits not loaded");

  a_lower_load: assert property (
    wr_ptr_lo |=> (ptr.addr[7:0] == $past(i_wdata)) &&
                  (ptr.addr[10:8] == $past(ptr.addr[10:8])))
    else $error("lower pointer bits not loaded");

  a_route_setup2: assert property (
    wr_ind && (indirect_sel == `RPS_SEL_SETUP2) |=>
      (setup2 == $past(i_wdata)) && $stable(setup1))
    else $error("indirect write misrouted");

  a_shared_select: assert property (
    wr_sub |=> (o_config[1:0] == $past(i_wdata[1:0])))
    else $error("selector pair not shared with configuration");

  a_cfg_select: assert property (
    wr_cfg |=> (indirect_sel[1:0] == $past(i_wdata[1:0])))
    else $error("configuration write did not reach selector pair");

  a_top_cleared: assert property (
    wr_cfg |=> !indirect_select_top_bit)
    else $error("top selector bit survived configuration write");

  c_seq_read: cover property (
    rd_data && ptr.read_direction_flag && ptr.pointer_step_enable
      ##1 rd_data);
  c_halt_resume: cover property (
    halt_req ##[1:20] !o_internal_halted);
  c_clear_rx: cover property (o_clear_rx_irq);
  c_carry_high: cover property (
    data_access && ptr.pointer_step_enable && (ptr.addr[7:0] == 8'hFF));
endmodule

// ==== test/rps_host.sv ====
// Host model: master on the plain register port of the pointer bank.
// Assumes the bank answers a read in the cycle after the strobe edge.
`timescale 1ns/1ps
module rps_host
  import rps_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  output rps_bus_s o_bus
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Idle port at time zero
  initial o_bus = '0;

  // One-cycle write; released lines show the inverse so that a stale
  // address or data byte can never pass for a held request
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_bus <= {1'b1, 1'b0, a, d};
    @(posedge i_mclk);
    o_bus <= {1'b0, 1'b0, ~a, ~d};
    #1;
  endtask

  // One-cycle read; data taken in the single cycle where it stands
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge i_mclk);
    o_bus <= {1'b0, 1'b1, a, 8'hA5};
    @(posedge i_mclk);
    o_bus <= {1'b0, 1'b0, ~a, 8'h5A};
    #1;
    q = i_rdata;
  endtask
endmodule

// ==== test/ram_pointer_and_subaddress_test.sv ====
// Self-checking bench of the pointer bank against an integer model.
// Assumes the host model drives the port; one 10 MHz clock.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module ram_pointer_and_subaddress_test;
  import rps_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] next_id = 8'h00;
  logic [7:0] rdata;
  logic clear_rx;
  logic halted_o;
  logic [7:0] cfg_o;
  logic [1:0] mult_o;
  rps_bus_s bus;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  // Reference state, reset values all zero
  int ram [2048];
  int ptr = 0, dir = 0, step = 0, sel = 0, cfg = 0;
  int tent = 0, node = 0, s1 = 0, s2 = 0, halted = 0;

  // 100 ns period
  always #50 i_mclk = ~i_mclk;

  rps_host rps_host_inst (.i_mclk(i_mclk), .i_rdata(rdata), .o_bus(bus));

  rps_top rps_top_inst (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(bus.addr),
    .i_wdata(bus.wdata), .i_wr(bus.wr), .i_rd(bus.rd),
    .i_next_node_id(next_id), .o_rdata(rdata),
    .o_clear_rx_irq(clear_rx), .o_internal_halted(halted_o),
    .o_config(cfg_o), .o_clock_mult_sel(mult_o)
  );

  // ****************************************************************
  // Closing report
  // ****************************************************************
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far above the roughly 600 cycles the run needs
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  // ****************************************************************
  // Model-driven register access
  // ****************************************************************
  // Write, update the model, then check every output the write touches
  task automatic mwr(input int a, input int d);
    int pulse;
    pulse = (a == 1 && d == 8'h08 && cfg[6]);
    rps_host_inst.wr(4'(a), 8'(d));
    case (a)
      2: begin dir = d[7]; step = d[6]; ptr = (d & 7) << 8 | ptr & 8'hFF; end
      3: ptr = ptr & 11'h700 | d;
      4:
      begin
        if (!dir) ram[ptr] = d;
        if (step) ptr = (ptr + 1) & 11'h7FF;
      end
      5: sel = d & 7;
      6: begin cfg = d; sel = d & 3; end
      7:
      case (sel)
        0: tent = d;
        1: node = d;
        2: s1 = d;
        4: begin if ((d ^ s2) & 8'hC0) halted = 1; s2 = d; end
        default: ;
      endcase
      default: ;
    endcase
    `CHK("clear_rx", 1'(pulse), clear_rx)
    `CHK("config", 8'((cfg & 8'hFC) | (sel & 3)), cfg_o)
    `CHK("mult_sel", 2'(s2 >> 6), mult_o)
    `CHK("halted", 1'(halted), halted_o)
    if (a == 1 && d == 8'h18) halted = 0;
  endtask

  // Read, compare with the model, step the model pointer on data reads
  task automatic mrd(input int a);
    int e;
    logic [7:0] q;
    case (a)
      0: e = halted;
      2: e = dir << 7 | step << 6 | ptr >> 8;
      3: e = ptr & 8'hFF;
      4: e = dir ? ram[ptr] : 0;
      5: e = sel;
      6: e = (cfg & 8'hFC) | (sel & 3);
      7: e = sel == 0 ? tent : sel == 1 ? node : sel == 2 ? s1 :
             sel == 3 ? int'(next_id) : sel == 4 ? s2 : 0;
      default: e = 0;
    endcase
    rps_host_inst.rd(4'(a), q);
    `CHK("rdata", 8'(e), q)
    if (a == 4 && step) ptr = (ptr + 1) & 11'h7FF;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    void'($urandom(32'hDFA81572));
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    // Reset values of every offset, unmapped ones included
    for (int a = 0; a < 16; a++) mrd(a);
    // Every selector code, reserved ones too; setup2 writes may halt
    for (int s = 0; s < 8; s++)
    begin
      // Network side value changes on a rising edge, like every input
      @(posedge i_mclk);
      next_id <= 8'($urandom);
      mwr(5, s);
      mwr(7, $urandom & 8'hFF);
      mrd(7);
      mrd(5);
      mrd(0);
    end
    // Multiplier change halts; restart command resumes two edges on
    mwr(5, 4);
    mwr(7, s2 ^ 8'hC0);
    mwr(7, s2 ^ 8'h40);
    mwr(1, 8'h18);
    @(posedge i_mclk);
    #1 `CHK("restart", 1'b0, halted_o)
    mwr(7, s2);
    mwr(1, 8'h18);
    mrd(0);
    // Shared low selector bits and top bit cleared by config write
    mwr(5, 7);
    mwr(6, $urandom & 8'hFF);
    mrd(5);
    mrd(6);
    mwr(5, 6);
    mrd(6);
    // Clear-receive command only with chaining enabled
    mwr(6, 0);
    mwr(1, 8'h08);
    mwr(6, 8'h40);
    mwr(1, 8'h08);
    mwr(1, 8'h55);
    mrd(1);
    // Pointer fields, carry across the low byte and wrap at the top
    for (int h = 0; h < 8; h++)
    begin
      mwr(2, 8'h78 | h);
      mwr(3, 8'hFE);
      repeat (3) mwr(4, $urandom & 8'hFF);
      mrd(2);
      mrd(3);
      mwr(2, 8'hC0 | h);
      mwr(3, 8'hFE);
      repeat (3) mrd(4);
      mwr(2, 8'h80 | h);
      mwr(3, 8'hFF);
      mrd(4);
      mrd(4);
      mrd(3);
      // Wrong direction: write not stored, read empty, both step
      mwr(2, 8'hC0 | h);
      mwr(3, 8'hFE);
      mwr(4, $urandom & 8'hFF);
      mwr(2, 8'h40 | h);
      mwr(3, 8'hFE);
      mrd(4);
      mrd(3);
      mwr(2, 8'h80 | h);
      mwr(3, 8'hFE);
      mrd(4);
    end
    test_done();
  end
endmodule
